// File: hw/dih_cfg.svh
`ifndef DIH_CFG_SVH
`define DIH_CFG_SVH

// register byte offsets on the host register port
`define DIH_OFS_DEVICE_INIT       8'h00
`define DIH_OFS_HOST_SPACE_CTRL   8'h0C
`define DIH_OFS_IRQ_ENABLE_0      8'h10
`define DIH_OFS_IRQ_ENABLE_1      8'h14

// device init register fields
`define DIH_DI_CFG_RESET_BIT      3
`define DIH_DI_FIFO_FLUSH_BIT     4
`define DIH_DI_HOST_EN_BIT        5
`define DIH_DI_ID_SEL_BIT         6
`define DIH_DI_CLKFREQ_LSB        8
`define DIH_DI_CLKFREQ_MSB        11
`define DIH_DI_ROM_RANGE_LSB      16
`define DIH_DI_ROM_RANGE_MSB      20
`define DIH_DI_CLKFREQ_RESET      4'h8
`define DIH_DI_ROM_RANGE_RESET    5'h1F

// host space control fields and resets
`define DIH_HC_CFG_WIN_BIT        0
`define DIH_HC_MCU_WIN_BIT        1
`define DIH_HC_RESET              2'h3

// interrupt enable 0 fields
`define DIH_IE0_CTRL_EP_BIT       0
`define DIH_IE0_EP_OUT_LSB        1
`define DIH_IE0_SETUP_BIT         7
`define DIH_IE0_DRAINED_BIT       8
`define DIH_IE0_CFG_RETRY_BIT     10
`define DIH_IE0_IN_TIMEOUT_BIT    11
`define DIH_IE0_EP_IN_LSB         17
// storage bits of enable 0: 0..8, 10, 11, 17..20
`define DIH_IE0_WRITE_MASK        32'h001E0DFF

// interrupt enable 1 fields
`define DIH_IE1_SOF_BIT           0
`define DIH_IE1_RESUME_BIT        1
`define DIH_IE1_SUSP_CHG_BIT      2
`define DIH_IE1_SUSP_REQ_BIT      3
`define DIH_IE1_PORT_RESET_BIT    4
`define DIH_IE1_CTRL_STATUS_BIT   6
`define DIH_IE1_BUS_POWER_BIT     7
`define DIH_IE1_EEPROM_DONE_BIT   8
`define DIH_IE1_DMA_LSB           9
`define DIH_IE1_GPIO_BIT          13
`define DIH_IE1_SOF_DOWN_BIT      14
`define DIH_IE1_MASTER_DONE_BIT   16
`define DIH_IE1_CA_BIT            19
`define DIH_IE1_UR_BIT            20
`define DIH_IE1_POISON_BIT        25
`define DIH_IE1_GLOBAL_BIT        31
// storage bits of enable 1: 0..20, 25, 31
`define DIH_IE1_WRITE_MASK        32'h821FFFFF

`define DIH_ENABLE_RESET          32'h00000000

`endif

// File: hw/dih_pkg.sv
package dih_pkg;

	// adapter personality, selects how endpoint gates are split
	typedef enum logic {
		DIH_LEGACY,
		DIH_ENHANCED
	} dih_mode_type;

	typedef logic [31:0] dih_word_type;

endpackage

// File: hw/dih_top.sv
`timescale 1ns/100ps
`include "dih_cfg.svh"

// Summary of operation
// RULE1: writing one to init bit 3 pulses a reset of all configuration registers; reads zero
// RULE2: writing one to init bit 4 pulses a flush of all endpoint FIFOs; reads zero
// RULE3: host access enable low makes every host access answer with retry
// RULE4: host access enable sets itself when no valid EEPROM and adapter mode
// RULE5: ID select chooses standard or subsystem IDs for the product/vendor ID read
// RULE6: init field 11:8 is plain storage, default 8h, no effect
// RULE7: ROM range field 20:16, default 1Fh, sizes ROM window in 2 KB steps
// RULE8: host software keeps ROM base a multiple of the configured range
// RULE9: host control bit 0, default one, enables the configuration space window
// RULE10: host control bit 1, default one, enables the microcontroller memory window
// RULE11: enable-0 bit 0 gates the control endpoint interrupt
// RULE12: enable-0 bits 1-4 gate endpoints 0-3, both directions legacy, OUT only enhanced
// RULE13: enable-0 bits 17-20 gate endpoint IN in enhanced mode, no effect in legacy
// RULE14: enable-0 bit 7 gates the setup packet interrupt
// RULE15: enable-0 bits 8, 10, 11 gate drained, configuration retry and IN FIFO timeout
// RULE16: enable-1 bits 0-4 gate SOF, resume, suspend change, suspend request, port reset
// RULE17: enable-1 bit 6 gates control status tokens, bit 7 bus power changes
// RULE18: enable-1 bit 8 gates serial EEPROM transaction completion
// RULE19: enable-1 bits 9-12 gate DMA channels A to D
// RULE20: enable-1 bit 13 gates GPIO, bit 14 gates SOF downcount reaching zero
// RULE21: enable-1 bit 16 gates master cycle completion, read data then in master data
// RULE22: enable-1 bits 19, 20, 25 gate completer abort, unsupported request, poisoned
// RULE23: nothing raises an interrupt message unless global enable bit 31 is set
// RULE24: software writes back read values into reserved-preserved bits
// RULE25: message request is OR of source AND enable, qualified by global, enables reset zero
module dih_top (
	input  wire logic                 clk,
	input  wire logic                 srst,
	// host register port
	input  wire logic                 reg_wr,
	input  wire logic                 reg_rd,
	input  wire logic [7:0]           reg_addr,
	input  wire logic [3:0]           reg_be,
	input  wire dih_pkg::dih_word_type reg_wdata,
	output logic      [31:0]          reg_rdata,
	output logic                      reg_rvalid,
	output logic                      reg_retry,
	// start-up status
	input  wire logic                 eeprom_load_done,
	input  wire logic                 eeprom_valid,
	input  wire logic                 adapter_mode,
	input  wire dih_pkg::dih_mode_type adapter_kind,
	// product/vendor ID selection
	input  wire logic [31:0]          standard_ids,
	input  wire logic [31:0]          subsystem_ids,
	output logic      [31:0]          product_vendor_id_reg,
	// control outputs
	output logic                      config_soft_reset,
	output logic                      fifo_flush,
	output logic                      host_access_en,
	output logic      [4:0]           rom_addr_mask,
	output logic                      config_space_window,
	output logic                      mcu_memory_window,
	// interrupt sources, enable-0 group
	input  wire logic                 control_endpoint_irq,
	input  wire logic [3:0]           ep_out_irq,
	input  wire logic [3:0]           ep_in_irq,
	input  wire logic                 setup_packet_irq,
	input  wire logic                 tlp_drained_irq,
	input  wire logic                 cfg_retry_irq,
	input  wire logic                 in_fifo_timeout_irq,
	// interrupt sources, enable-1 group
	input  wire logic                 sof_irq,
	input  wire logic                 resume_irq,
	input  wire logic                 suspend_change_irq,
	input  wire logic                 suspend_request_irq,
	input  wire logic                 port_reset_irq,
	input  wire logic                 control_status_irq,
	input  wire logic                 bus_power_sense_irq,
	input  wire logic                 eeprom_done_irq,
	input  wire logic [3:0]           dma_irq,
	input  wire logic                 gpio_irq,
	input  wire logic                 sof_downcount_irq,
	input  wire logic                 master_done_irq,
	input  wire logic                 completer_abort_irq,
	input  wire logic                 unsupported_req_irq,
	input  wire logic                 poisoned_irq,
	output logic                      irq_msg_req
);
	import dih_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// storage

	// device init fields
	logic        cfg_reset_q;
	logic        fifo_flush_q;
	logic        host_en_q;
	logic        id_sel_q;
	logic [3:0]  clk_freq_q;
	logic [4:0]  rom_range_q;

	// host control and enables
	logic [1:0]  host_ctrl_q;
	logic [31:0] irq_en0_q;
	logic [31:0] irq_en1_q;

	// port answer and ID word
	logic [31:0] rdata_q;
	logic        rvalid_q;
	logic        retry_q;
	logic [31:0] pvid_q;

	// interrupt path
	logic        irq_q;
	logic [31:0] irq_src0_d;
	logic [31:0] irq_src1_d;
	logic        irq_d;

	// write decode
	logic        access_ok;
	logic        wr_init;
	logic        wr_hctl;
	logic        wr_en0;
	logic        wr_en1;
	logic [31:0] init_word;

	////////////////////////////////////////////////////////////////////////////
	// helpers

	// merge write data into an old word, lane by lane, only on storage bits
	function automatic logic [31:0] merge_lanes(input logic [31:0] old_w,
		input logic [31:0] new_w, input logic [3:0] be, input logic [31:0] wmask);
		logic [31:0] lane_m;
		lane_m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}} & wmask;
		return (old_w & ~lane_m) | (new_w & lane_m);
	endfunction

	// one-hot-free address match, used by the write decode only; reads decode with a case
	function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
		return addr == ofs;
	endfunction

	// a retried access neither stores nor returns data
	// unmapped writes match no strobe and vanish
	assign access_ok = host_en_q; // see RULE3
	assign wr_init = reg_wr && access_ok && hit(reg_addr, `DIH_OFS_DEVICE_INIT);
	assign wr_hctl = reg_wr && access_ok && hit(reg_addr, `DIH_OFS_HOST_SPACE_CTRL);
	assign wr_en0  = reg_wr && access_ok && hit(reg_addr, `DIH_OFS_IRQ_ENABLE_0);
	assign wr_en1  = reg_wr && access_ok && hit(reg_addr, `DIH_OFS_IRQ_ENABLE_1);

	// readable image of the init register; self-clearing strobes read zero
	always_comb begin
		init_word = 32'h0000_0000;
		init_word[`DIH_DI_HOST_EN_BIT] = host_en_q;
		init_word[`DIH_DI_ID_SEL_BIT] = id_sel_q;
		init_word[`DIH_DI_CLKFREQ_MSB:`DIH_DI_CLKFREQ_LSB] = clk_freq_q; // see RULE6
		init_word[`DIH_DI_ROM_RANGE_MSB:`DIH_DI_ROM_RANGE_LSB] = rom_range_q;
	end

	////////////////////////////////////////////////////////////////////////////
	// device init register

	// soft reset strobes last one cycle; a byte write that skips lane 0 leaves them idle
	// they read back zero, so the host sees only their effect
	always_ff @(posedge clk) begin
		if (srst) begin
			cfg_reset_q  <= 1'b0;
			fifo_flush_q <= 1'b0;
		end else begin
			cfg_reset_q  <= wr_init && reg_be[0] && reg_wdata[`DIH_DI_CFG_RESET_BIT]; // see RULE1
			fifo_flush_q <= wr_init && reg_be[0] && reg_wdata[`DIH_DI_FIFO_FLUSH_BIT]; // see RULE2
		end
	end

	// host access enable: the start-up fallback wins over a host write in the same cycle
	// without it a board with no EEPROM is never reachable
	always_ff @(posedge clk) begin
		if (srst) begin
			host_en_q <= 1'b0;
		end else if (eeprom_load_done && !eeprom_valid && adapter_mode) begin
			host_en_q <= 1'b1; // see RULE4
		end else if (wr_init && reg_be[0]) begin
			host_en_q <= reg_wdata[`DIH_DI_HOST_EN_BIT]; // see RULE3
		end
	end

	// ID select and the no-effect clock frequency field
	always_ff @(posedge clk) begin
		if (srst) begin
			id_sel_q   <= 1'b0;
			clk_freq_q <= `DIH_DI_CLKFREQ_RESET;
		end else if (wr_init) begin
			if (reg_be[0]) begin
				id_sel_q <= reg_wdata[`DIH_DI_ID_SEL_BIT]; // see RULE5
			end
			if (reg_be[1]) begin
				clk_freq_q <= reg_wdata[`DIH_DI_CLKFREQ_MSB:`DIH_DI_CLKFREQ_LSB]; // see RULE6
			end
		end
	end

	// ROM range; base alignment is software's duty, the mask does not check it
	// any pattern is kept as written, contiguous or not
	always_ff @(posedge clk) begin
		if (srst) begin
			rom_range_q <= `DIH_DI_ROM_RANGE_RESET;
		end else if (wr_init && reg_be[2]) begin
			rom_range_q <= reg_wdata[`DIH_DI_ROM_RANGE_MSB:`DIH_DI_ROM_RANGE_LSB]; // see RULE7
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// host space control and interrupt enables

	// only the two window bits are stored
	always_ff @(posedge clk) begin
		if (srst) begin
			host_ctrl_q <= `DIH_HC_RESET;
		end else if (wr_hctl && reg_be[0]) begin
			host_ctrl_q[`DIH_HC_CFG_WIN_BIT] <= reg_wdata[`DIH_HC_CFG_WIN_BIT]; // see RULE9
			host_ctrl_q[`DIH_HC_MCU_WIN_BIT] <= reg_wdata[`DIH_HC_MCU_WIN_BIT]; // see RULE10
		end
	end

	// only storage bits move; the rest stay zero whatever software writes
	// legacy keeps bits 17-20 writable with nothing behind them
	always_ff @(posedge clk) begin
		if (srst) begin
			irq_en0_q <= `DIH_ENABLE_RESET; // see RULE25
			irq_en1_q <= `DIH_ENABLE_RESET;
		end else begin
			if (wr_en0) begin
				irq_en0_q <= merge_lanes(irq_en0_q, reg_wdata, reg_be, `DIH_IE0_WRITE_MASK);
			end
			if (wr_en1) begin
				irq_en1_q <= merge_lanes(irq_en1_q, reg_wdata, reg_be, `DIH_IE1_WRITE_MASK);
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// register read and retry answer

	// answer one cycle after the request; unmapped offsets read zero
	// data is zero between answers so no stale word looks valid
	always_ff @(posedge clk) begin
		if (srst) begin
			rdata_q  <= 32'h0000_0000;
			rvalid_q <= 1'b0;
			retry_q  <= 1'b0;
		end else begin
			retry_q  <= (reg_rd || reg_wr) && !access_ok; // see RULE3
			rvalid_q <= reg_rd && access_ok;
			if (reg_rd && access_ok) begin
				unique case (reg_addr)
					`DIH_OFS_DEVICE_INIT:     rdata_q <= init_word; // see RULE1
					`DIH_OFS_HOST_SPACE_CTRL: rdata_q <= {30'h0, host_ctrl_q};
					`DIH_OFS_IRQ_ENABLE_0:    rdata_q <= irq_en0_q;
					`DIH_OFS_IRQ_ENABLE_1:    rdata_q <= irq_en1_q;
					default:                  rdata_q <= 32'h0000_0000;
				endcase
			end else begin
				rdata_q <= 32'h0000_0000;
			end
		end
	end

	// ID value presented to whoever serves the product/vendor ID read
	// one cycle of lag is far shorter than any ID read
	always_ff @(posedge clk) begin
		if (srst) begin
			pvid_q <= 32'h0000_0000;
		end else begin
			pvid_q <= id_sel_q ? subsystem_ids : standard_ids; // see RULE5
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// interrupt message request

	// sources laid out on the enable-0 bit positions
	// reserved gates get no source, so setting them does nothing
	always_comb begin
		irq_src0_d = 32'h0000_0000;
		irq_src0_d[`DIH_IE0_CTRL_EP_BIT] = control_endpoint_irq; // see RULE11
		if (adapter_kind == DIH_ENHANCED) begin
			irq_src0_d[`DIH_IE0_EP_OUT_LSB +: 4] = ep_out_irq; // see RULE12
			irq_src0_d[`DIH_IE0_EP_IN_LSB +: 4]  = ep_in_irq; // see RULE13
		end else begin
			// legacy: one gate per endpoint, both directions, upper gates idle
			irq_src0_d[`DIH_IE0_EP_OUT_LSB +: 4] = ep_out_irq | ep_in_irq; // see RULE12
		end
		irq_src0_d[`DIH_IE0_SETUP_BIT]      = setup_packet_irq; // see RULE14
		irq_src0_d[`DIH_IE0_DRAINED_BIT]    = tlp_drained_irq; // see RULE15
		irq_src0_d[`DIH_IE0_CFG_RETRY_BIT]  = cfg_retry_irq;
		irq_src0_d[`DIH_IE0_IN_TIMEOUT_BIT] = in_fifo_timeout_irq;
	end

	// sources laid out on the enable-1 bit positions
	always_comb begin
		irq_src1_d = 32'h0000_0000;
		irq_src1_d[`DIH_IE1_SOF_BIT]         = sof_irq; // see RULE16
		irq_src1_d[`DIH_IE1_RESUME_BIT]      = resume_irq;
		irq_src1_d[`DIH_IE1_SUSP_CHG_BIT]    = suspend_change_irq;
		irq_src1_d[`DIH_IE1_SUSP_REQ_BIT]    = suspend_request_irq;
		irq_src1_d[`DIH_IE1_PORT_RESET_BIT]  = port_reset_irq;
		irq_src1_d[`DIH_IE1_CTRL_STATUS_BIT] = control_status_irq; // see RULE17
		irq_src1_d[`DIH_IE1_BUS_POWER_BIT]   = bus_power_sense_irq;
		irq_src1_d[`DIH_IE1_EEPROM_DONE_BIT] = eeprom_done_irq; // see RULE18
		irq_src1_d[`DIH_IE1_DMA_LSB +: 4]    = dma_irq; // see RULE19
		irq_src1_d[`DIH_IE1_GPIO_BIT]        = gpio_irq; // see RULE20
		irq_src1_d[`DIH_IE1_SOF_DOWN_BIT]    = sof_downcount_irq;
		irq_src1_d[`DIH_IE1_MASTER_DONE_BIT] = master_done_irq; // see RULE21
		irq_src1_d[`DIH_IE1_CA_BIT]          = completer_abort_irq; // see RULE22
		irq_src1_d[`DIH_IE1_UR_BIT]          = unsupported_req_irq;
		irq_src1_d[`DIH_IE1_POISON_BIT]      = poisoned_irq;
	end

	// global bit is masked out of the OR so it cannot raise a request on its own
	// a source held high keeps the request up; no edge memory
	assign irq_d = irq_en1_q[`DIH_IE1_GLOBAL_BIT] && // see RULE23
		(|(irq_src0_d & irq_en0_q) || |(irq_src1_d & irq_en1_q)); // see RULE25

	// request is a level that follows the sources one cycle late
	always_ff @(posedge clk) begin
		if (srst) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= irq_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// outputs

	// each output is a flop, so no decode glitch reaches a pin
	assign reg_rdata             = rdata_q;
	assign reg_rvalid            = rvalid_q;
	assign reg_retry             = retry_q;
	assign product_vendor_id_reg = pvid_q;
	assign config_soft_reset     = cfg_reset_q;
	assign fifo_flush            = fifo_flush_q;
	assign host_access_en        = host_en_q;
	assign rom_addr_mask         = rom_range_q; // set bit = address bit 11+n compared
	assign config_space_window   = host_ctrl_q[`DIH_HC_CFG_WIN_BIT];
	assign mcu_memory_window     = host_ctrl_q[`DIH_HC_MCU_WIN_BIT];
	assign irq_msg_req           = irq_q;

endmodule

// File: test/dih_properties.sv
`timescale 1ns/100ps
`include "dih_cfg.svh"
////////////////////////////////////////////////////////////////////////////////
// watches the host register port and the control strobes of the top module
module dih_properties (
	input logic                  clk,
	input logic                  srst,
	input logic                  reg_wr,
	input logic                  reg_rd,
	input logic [7:0]            reg_addr,
	input logic [3:0]            reg_be,
	input dih_pkg::dih_word_type reg_wdata,
	input logic [31:0]           reg_rdata,
	input logic                  reg_rvalid,
	input logic                  reg_retry,
	input logic                  eeprom_load_done,
	input logic                  eeprom_valid,
	input logic                  adapter_mode,
	input logic                  config_soft_reset,
	input logic                  fifo_flush,
	input logic                  host_access_en,
	input logic [4:0]            rom_addr_mask,
	input logic                  config_space_window,
	input logic                  mcu_memory_window
);
	import dih_pkg::*;
	default clocking @(posedge clk); endclocking
	default disable iff (srst);
	logic req;
	logic wr_init;
	// helpers: any request, and an accepted write that reaches the strobe lane
	assign req = reg_wr | reg_rd;
	assign wr_init = reg_wr & host_access_en & (reg_addr == `DIH_OFS_DEVICE_INIT) & reg_be[0];
	////////////////////////////////////////////////////////////////////////////
	AST_RETRY: assert property (req && !host_access_en |=> reg_retry && !reg_rvalid)
		else $error("access while disabled was not retried");
	AST_RETRY_CAUSE: assert property (reg_retry |-> $past(req && !host_access_en))
		else $error("retry without a disabled access");
	AST_READ_ANSWER: assert property (reg_rd && host_access_en |=> reg_rvalid && !reg_retry)
		else $error("enabled read not answered normally");
	AST_HOST_EN_HOLD: assert property (host_access_en && !(reg_wr && reg_addr == 8'h00 && reg_be[0]) |=> host_access_en)
		else $error("host access enable dropped without a write");
	AST_HOST_EN_AUTO: assert property (eeprom_load_done && !eeprom_valid && adapter_mode |=> host_access_en)
		else $error("host access enable not set after load");
	AST_CFG_RESET: assert property (config_soft_reset == $past(wr_init && reg_wdata[3]))
		else $error("configuration reset strobe wrong");
	AST_FIFO_FLUSH: assert property (fifo_flush == $past(wr_init && reg_wdata[4]))
		else $error("fifo flush strobe wrong");
	AST_STROBES_READ_ZERO: assert property (reg_rd && host_access_en && reg_addr == 8'h00 |=> reg_rdata[4:3] == 2'h0)
		else $error("strobe bits read back nonzero");
	AST_ROM_MASK: assert property (reg_wr && host_access_en && reg_addr == 8'h00 && reg_be[2]
		|=> rom_addr_mask == $past(reg_wdata[20:16]))
		else $error("rom range not taken from write");
	AST_WINDOWS: assert property (reg_wr && host_access_en && reg_addr == 8'h0C && reg_be[0]
		|=> config_space_window == $past(reg_wdata[0]) && mcu_memory_window == $past(reg_wdata[1]))
		else $error("window enables not taken from write");
	// main scenarios reached
	cover property (reg_retry);
	cover property (config_soft_reset && fifo_flush);
	cover property (reg_rvalid && reg_rdata != 32'h00000000);
endmodule
bind dih_top dih_properties i_props (.*);

// File: test/dih_host_model.sv
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////////
// host side of the register port
module dih_host_model (
	input  logic                  clk,
	output logic                  reg_wr,
	output logic                  reg_rd,
	output logic [7:0]            reg_addr,
	output logic [3:0]            reg_be,
	output dih_pkg::dih_word_type reg_wdata,
	input  logic [31:0]           reg_rdata,
	input  logic                  reg_rvalid,
	input  logic                  reg_retry
);
	import dih_pkg::*;
	// quiet bus from time zero
	initial begin
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 8'h00;
		reg_be = 4'h0;
		reg_wdata = 32'h00000000;
	end
	// one request held for its taking edge, answer read just after that edge;
	// preserved bits go out as the caller gives them, never read back first; rom base never moved here
	task automatic access(input logic w, input logic [7:0] a, input logic [3:0] b, input dih_word_type d,
			output logic [31:0] q, output logic v, output logic t);
		@(posedge clk);
		reg_wr <= w;
		reg_rd <= !w;
		reg_addr <= a;
		reg_be <= b;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
		reg_rd <= 1'b0;
		// released lines stop showing the old word, so no stale match
		reg_addr <= ~a;
		reg_be <= ~b;
		reg_wdata <= ~d;
		#1;
		q = reg_rdata;
		v = reg_rvalid;
		t = reg_retry;
	endtask
endmodule

// File: test/test_device_init_and_host_irq_enables.sv
`timescale 1ns/100ps
`include "dih_cfg.svh"
module test_device_init_and_host_irq_enables;
	import dih_pkg::*;
	localparam logic [31:0] glb = 32'h80000000;
	logic clk, srst, eeprom_load_done, eeprom_valid, adapter_mode, irq_msg_req, reg_wr, reg_rd, reg_rvalid, reg_retry;
	logic config_soft_reset, fifo_flush, host_access_en, config_space_window, mcu_memory_window;
	logic [31:0] s0, s1, standard_ids, subsystem_ids, product_vendor_id_reg, reg_rdata;
	logic [7:0] reg_addr;
	logic [3:0] reg_be;
	logic [4:0] rom_addr_mask;
	dih_word_type reg_wdata;
	dih_mode_type adapter_kind;
	int fails, check_count, cycles;
	////////////////////////////////////////////////////////////////////////////
	dih_host_model i_host (.*);
	dih_top i_dut (.*, .control_endpoint_irq(s0[0]), .ep_out_irq(s0[4:1]), .ep_in_irq(s0[20:17]),
		.setup_packet_irq(s0[7]), .tlp_drained_irq(s0[8]), .cfg_retry_irq(s0[10]), .in_fifo_timeout_irq(s0[11]),
		.sof_irq(s1[0]), .resume_irq(s1[1]), .suspend_change_irq(s1[2]), .suspend_request_irq(s1[3]),
		.port_reset_irq(s1[4]), .control_status_irq(s1[6]), .bus_power_sense_irq(s1[7]), .eeprom_done_irq(s1[8]),
		.dma_irq(s1[12:9]), .gpio_irq(s1[13]), .sof_downcount_irq(s1[14]), .master_done_irq(s1[16]),
		.completer_abort_irq(s1[19]), .unsupported_req_irq(s1[20]), .poisoned_irq(s1[25]));
	// 50 MHz clock
	always #10 clk = ~clk;
	// hang guard, well above the fewer than one thousand cycles the run needs
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			fails++;
			complete_run();
		end
	end
	////////////////////////////////////////////////////////////////////////////
	task automatic complete_run();
		if (fails == 0 && check_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			fails++;
			$display("unexpected value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic check_bit(input logic got, input logic exp);
		check_word({31'h0, got}, {31'h0, exp});
	endtask
	// one access; r says whether a retry is due, reads also judge the data
	task automatic xfer(input logic w, input logic [7:0] a, input logic [3:0] b, input logic [31:0] d,
			input logic [31:0] e, input logic r);
		logic [31:0] got;
		logic v, t;
		i_host.access(w, a, b, d, got, v, t);
		check_bit(t, r);
		if (!w) begin
			check_bit(v, !r);
			check_word(got, r ? 32'h00000000 : e);
		end
	endtask
	task automatic rd_reg(input logic [7:0] a, input logic [31:0] e);
		xfer(1'b0, a, 4'hF, 32'h00000000, e, 1'b0);
	endtask
	task automatic wr_reg(input logic [7:0] a, input logic [3:0] b, input logic [31:0] d);
		xfer(1'b1, a, b, d, 32'h00000000, 1'b0);
	endtask
	// start-up load finished, with the given verdict on the eeprom
	task automatic ee_load(input logic v);
		@(posedge clk);
		eeprom_valid <= v;
		eeprom_load_done <= 1'b1;
		@(posedge clk);
		eeprom_load_done <= 1'b0;
		@(posedge clk);
		#1;
	endtask
	// request expected from mode, enables and sources
	function automatic logic exp_irq(input dih_mode_type m, input logic [31:0] e0, input logic [31:0] e1,
			input logic [31:0] a0, input logic [31:0] a1);
		logic [31:0] g0;
		// only gates with an event behind them; reserved storage bits gate nothing
		g0 = e0 & 32'h001E0D9F;
		if (m == DIH_LEGACY)
			g0[20:17] = g0[4:1];
		return e1[31] && ((|(a0 & g0)) || (|(a1 & e1 & 32'h02197FDF)));
	endfunction
	task automatic irq_case(input dih_mode_type m, input logic [31:0] e0, input logic [31:0] e1,
			input logic [31:0] a0, input logic [31:0] a1);
		wr_reg(`DIH_OFS_IRQ_ENABLE_0, 4'hF, e0);
		wr_reg(`DIH_OFS_IRQ_ENABLE_1, 4'hF, e1);
		@(posedge clk);
		adapter_kind <= m;
		s0 <= a0;
		s1 <= a1;
		repeat (2) @(posedge clk);
		#1;
		check_bit(irq_msg_req, exp_irq(m, e0, e1, a0, a1));
	endtask
	////////////////////////////////////////////////////////////////////////////
	task automatic sc_defaults();
		check_bit(config_space_window, 1'b1);
		check_bit(mcu_memory_window, 1'b1);
		check_word({27'h0, rom_addr_mask}, 32'h0000001F);
		check_bit(irq_msg_req, 1'b0);
		xfer(1'b0, `DIH_OFS_DEVICE_INIT, 4'hF, 32'h0, 32'h0, 1'b1);
		xfer(1'b1, `DIH_OFS_IRQ_ENABLE_1, 4'hF, 32'hFFFFFFFF, 32'h0, 1'b1);
	endtask
	task automatic sc_auto_enable();
		ee_load(1'b1);
		check_bit(host_access_en, 1'b0);
		ee_load(1'b0);
		check_bit(host_access_en, 1'b1);
		rd_reg(`DIH_OFS_DEVICE_INIT, 32'h001F0820);
		rd_reg(`DIH_OFS_IRQ_ENABLE_1, 32'h00000000);
		rd_reg(8'h04, 32'h00000000);
	endtask
	task automatic sc_device_init();
		wr_reg(`DIH_OFS_DEVICE_INIT, 4'hF, 32'h80150AF8);
		check_bit(config_soft_reset, 1'b1);
		check_bit(fifo_flush, 1'b1);
		@(posedge clk);
		#1;
		check_bit(config_soft_reset, 1'b0);
		check_word(product_vendor_id_reg, subsystem_ids);
		check_word({27'h0, rom_addr_mask}, 32'h00000015);
		rd_reg(`DIH_OFS_DEVICE_INIT, 32'h00150A60);
		wr_reg(`DIH_OFS_DEVICE_INIT, 4'h4, 32'hFFE0FFFF);
		wr_reg(`DIH_OFS_DEVICE_INIT, 4'h1, 32'h00000020);
		@(posedge clk);
		#1;
		check_word(product_vendor_id_reg, standard_ids);
		rd_reg(`DIH_OFS_DEVICE_INIT, 32'h00000A20);
	endtask
	task automatic sc_host_ctrl();
		rd_reg(`DIH_OFS_HOST_SPACE_CTRL, 32'h00000003);
		wr_reg(`DIH_OFS_HOST_SPACE_CTRL, 4'hF, 32'hFFFFFFFE);
		check_bit(config_space_window, 1'b0);
		check_bit(mcu_memory_window, 1'b1);
		wr_reg(`DIH_OFS_HOST_SPACE_CTRL, 4'h0, 32'h00000001);
		rd_reg(`DIH_OFS_HOST_SPACE_CTRL, 32'h00000002);
	endtask
	// every gate alone, and each enable-1 gate also shut while the rest are open
	task automatic sc_irq();
		irq_case(DIH_LEGACY, 32'hFFFFFFFF, ~glb, 32'hFFFFFFFF, 32'hFFFFFFFF);
		for (int b = 0; b < 31; b++) begin
			if (`DIH_IE1_WRITE_MASK & (32'h1 << b)) begin
				irq_case(DIH_LEGACY, 32'h0, glb | (32'h1 << b), 32'h0, 32'h1 << b);
				irq_case(DIH_LEGACY, 32'h0, ~(32'h1 << b), 32'h0, 32'h1 << b);
			end
		end
		for (int m = 0; m < 2; m++) begin
			for (int b = 0; b < 21; b++) begin
				if (`DIH_IE0_WRITE_MASK & (32'h1 << b))
					irq_case(dih_mode_type'(m), 32'h1 << b, glb, 32'h1 << b, 32'h0);
				if (b >= 1 && b <= 4)
					irq_case(dih_mode_type'(m), 32'h1 << b, glb, 32'h1 << (b + 16), 32'h0);
			end
		end
	endtask
	task automatic sc_disable();
		wr_reg(`DIH_OFS_DEVICE_INIT, 4'h1, 32'h00000000);
		xfer(1'b0, `DIH_OFS_HOST_SPACE_CTRL, 4'hF, 32'h0, 32'h0, 1'b1);
		xfer(1'b1, `DIH_OFS_HOST_SPACE_CTRL, 4'hF, 32'h0, 32'h0, 1'b1);
		check_bit(mcu_memory_window, 1'b1);
		ee_load(1'b0);
		rd_reg(`DIH_OFS_HOST_SPACE_CTRL, 32'h00000002);
	endtask
	// a second reset in mid-run, sources still active
	task automatic sc_mid_reset();
		@(posedge clk);
		srst <= 1'b1;
		repeat (2) @(posedge clk);
		srst <= 1'b0;
		#1;
		check_bit(host_access_en, 1'b0);
		ee_load(1'b0);
		check_bit(irq_msg_req, 1'b0);
		rd_reg(`DIH_OFS_IRQ_ENABLE_0, 32'h00000000);
		rd_reg(`DIH_OFS_HOST_SPACE_CTRL, 32'h00000003);
	endtask
	////////////////////////////////////////////////////////////////////////////
	// reset for 12 cycles, then the scenarios in turn
	initial begin
		clk = 1'b0;
		srst = 1'b1;
		eeprom_load_done = 1'b0;
		eeprom_valid = 1'b0;
		adapter_mode = 1'b1;
		adapter_kind = DIH_LEGACY;
		standard_ids = 32'h0000A5A5; // arbitrary id word
		subsystem_ids = 32'h00005A5A; // arbitrary id word
		s0 = 32'h00000000;
		s1 = 32'h00000000;
		fails = 0;
		check_count = 0;
		cycles = 0;
		repeat (12) @(posedge clk);
		srst <= 1'b0;
		@(posedge clk);
		#1;
		sc_defaults();
		sc_auto_enable();
		sc_device_init();
		sc_host_ctrl();
		sc_irq();
		sc_disable();
		sc_mid_reset();
		complete_run();
	end
endmodule
